//--- rtl/flash_guard.sv
// Flash fault status, sector protection and command guard with an APB slave
//
// Behaviour
// - Double fault or busy-block read sets double flag
// - Writing one clears double flag, zero ignored
// - Unless ignored, single fault or collision sets single
// - Writing one clears single flag, zero ignored
// - Parity fault is single or double, never both
// - Read colliding with command sets both flags; only double if ignored
// - Flags stored one cycle after read; software waits
// - Protection writes accepted only when region grows
// - Protection loaded from nonvolatile byte at reset
// - Protected program or erase refused, violation set
// - Block erase refused if any sector protected
// - Operation bit zero: ranges are unprotected holes
// - Operation bit one: ranges are protected
// - High disable bit five governs top-ending range
// - High size bits four-three written only while disabled
// - Protection bit six reads as one always
// - Violation flag blocks command launch and sequences
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "flash_guard_consts.svh"

module flash_guard (
	// Clock and reset
	input  wire logic                       core_clk,
	input  wire logic                       rst_n,
	// APB slave
	input  wire logic [15:0]                paddr,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [31:0]                pwdata,
	input  wire logic [3:0]                 pstrb,
	output var  logic [31:0]                prdata,
	output var  logic                       pready,
	output var  logic                       pslverr,
	// Nonvolatile protection byte from the reset sequence
	input  wire logic                       nv_load_valid,
	input  wire logic [7:0]                 nv_prot_byte,
	// Flash array read report
	input  wire logic                       rd_done,
	input  wire logic                       rd_ecc_single,
	input  wire logic                       rd_ecc_double,
	input  wire logic                       rd_busy_collide,
	// Program and erase requests
	input  wire logic                       cmd_req,
	input  wire flash_guard_pkg::cmd_kind_t cmd_kind,
	input  wire logic [15:0]                cmd_addr,
	output var  logic                       cmd_start,
	output var  logic                       cmd_refuse,
	output var  logic                       launch_blocked,
	// Interrupt
	output var  logic                       irq
);

	// ======================================================================
	// Declarations
	logic                          pready_q;
	logic [31:0]                   prdata_q;
	logic                          pslverr_q;
	logic                          wr_en;
	logic                          rd_fin;
	logic                          setup_acc;
	logic                          hit_flt;
	logic                          hit_prot;
	logic                          hit_cfg;
	logic                          hit_cst;
	logic                          hit_ist;
	logic                          hit_imsk;
	logic                          mapped;
	logic [31:0]                   rd_mux;
	logic                          ign_q;
	logic [2:0]                    imask_q;
	flash_guard_pkg::prot_fields_t prot_q;
	flash_guard_pkg::prot_fields_t cand;
	logic [7:0]                    prot_view;
	logic                          addr_protected;
	logic                          any_protected;
	logic                          cand_grows;
	logic [1:0]                    flt_set;
	logic [1:0]                    flt_clr;
	logic [1:0]                    flt_q;
	logic                          viol_q;
	logic                          viol_set;
	logic                          viol_clr;
	logic                          cmd_is_prot;
	logic [2:0]                    ist_set;
	logic [2:0]                    ist_clr;
	logic [2:0]                    ist_q;
	logic                          cmd_start_q;
	logic                          cmd_refuse_q;
	logic                          irq_q;

	// ======================================================================
	// APB decode
	assign setup_acc = psel && penable && !pready_q;
	assign wr_en     = psel && penable && pready_q && pwrite && pstrb[0];
	assign rd_fin    = psel && penable && pready_q && !pwrite;

	// Address decode, one aligned word per register
	always_comb
	begin
		{hit_flt, hit_prot, hit_cfg, hit_cst, hit_ist, hit_imsk} = 6'h00;
		if (paddr == `FLT_ADDR)
			hit_flt = 1'b1;
		else if (paddr == `PROT_ADDR)
			hit_prot = 1'b1;
		else if (paddr == `CFG_ADDR)
			hit_cfg = 1'b1;
		else if (paddr == `CST_ADDR)
			hit_cst = 1'b1;
		else if (paddr == `IST_ADDR)
			hit_ist = 1'b1;
		else if (paddr == `IMSK_ADDR)
			hit_imsk = 1'b1;
	end
	assign mapped = hit_flt || hit_prot || hit_cfg || hit_cst || hit_ist || hit_imsk;

	// Protection register view with fixed reserved bits
	assign prot_view = {prot_q.open, 1'b1, prot_q.hdis, prot_q.hsize, 3'h0};

	// Read data mux; unused upper bits read zero, reserved bits as fixed in each view
	always_comb
	begin
		rd_mux = 32'h00000000;
		if (hit_flt)
			rd_mux = {30'h00000000, flt_q};
		else if (hit_prot)
			rd_mux = {24'h000000, prot_view};
		else if (hit_cfg)
			rd_mux = {31'h00000000, ign_q};
		else if (hit_cst)
			rd_mux = {27'h0000000, viol_q, 4'h0};
		else if (hit_ist)
			rd_mux = {29'h00000000, ist_q};
		else if (hit_imsk)
			rd_mux = {29'h00000000, imask_q};
	end

	// One wait state: ready rises in the second access cycle
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			pready_q <= 1'b0;
		else
			pready_q <= setup_acc;
	end

	// Read data and error captured in the first access cycle
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end
		else if (setup_acc)
		begin
			prdata_q  <= pwrite ? 32'h00000000 : rd_mux;
			pslverr_q <= !mapped;
		end
		else
			pslverr_q <= 1'b0;
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	// ======================================================================
	// Configuration and interrupt mask registers
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ign_q   <= 1'b0;
			imask_q <= 3'h0;
		end
		else if (wr_en && hit_cfg)
			ign_q <= pwdata[`CFG_IGN_BIT];
		else if (wr_en && hit_imsk)
			imask_q <= pwdata[2:0];
	end

	// ======================================================================
	// Fault status flags
	always_comb
	begin
		flt_set[`FLT_DBL_BIT] = rd_done && (rd_ecc_double || rd_busy_collide);
		flt_set[`FLT_SGL_BIT] = rd_done && !ign_q
			&& ((rd_ecc_single && !rd_ecc_double) || rd_busy_collide);
		flt_clr[`FLT_DBL_BIT] = wr_en && hit_flt && pwdata[`FLT_DBL_BIT];
		flt_clr[`FLT_SGL_BIT] = wr_en && hit_flt && pwdata[`FLT_SGL_BIT];
	end

	// Flags land at the edge after the read report
	fault_flag_bank #(
		.N(2)
	) u_flt (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.set_i    (flt_set),
		.clr_i    (flt_clr),
		.flags_q  (flt_q)
	);

	// ======================================================================
	// Protection register
	assign cand.open  = pwdata[`PROT_OPEN_BIT];
	assign cand.hdis  = pwdata[`PROT_HDIS_BIT];
	assign cand.hsize = prot_q.hdis ? pwdata[`PROT_HS_HI:`PROT_HS_LO] : prot_q.hsize;

	prot_range_check u_chk (
		.cur            (prot_q),
		.cand           (cand),
		.addr           (cmd_addr),
		.addr_protected (addr_protected),
		.any_protected  (any_protected),
		.cand_grows     (cand_grows)
	);

	// Reset sequence load, then only growing writes
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prot_q.open  <= `PROT_RST_OPEN;
			prot_q.hdis  <= `PROT_RST_HDIS;
			prot_q.hsize <= `PROT_RST_HS;
		end
		else if (nv_load_valid)
		begin
			prot_q.open  <= nv_prot_byte[`PROT_OPEN_BIT];
			prot_q.hdis  <= nv_prot_byte[`PROT_HDIS_BIT];
			prot_q.hsize <= nv_prot_byte[`PROT_HS_HI:`PROT_HS_LO];
		end
		else if (wr_en && hit_prot && cand_grows)
			prot_q <= cand;
	end

	// ======================================================================
	// Command guard
	assign cmd_is_prot = (cmd_kind == flash_guard_pkg::CMD_BLOCK_ERASE) ? any_protected
		: (cmd_kind != flash_guard_pkg::CMD_OTHER) && addr_protected;
	assign viol_set    = cmd_req && !viol_q && cmd_is_prot;
	assign viol_clr    = wr_en && hit_cst && pwdata[`CST_VIOL_BIT];

	// Violation flag, set wins over a same-cycle clear
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			viol_q <= 1'b0;
		else if (viol_set)
			viol_q <= 1'b1;
		else if (viol_clr)
			viol_q <= 1'b0;
	end

	// Start or refuse pulse one cycle after the request
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmd_start_q  <= 1'b0;
			cmd_refuse_q <= 1'b0;
		end
		else
		begin
			cmd_start_q  <= cmd_req && !viol_q && !cmd_is_prot;
			cmd_refuse_q <= cmd_req && (viol_q || cmd_is_prot);
		end
	end

	assign cmd_start      = cmd_start_q;
	assign cmd_refuse     = cmd_refuse_q;
	assign launch_blocked = viol_q;

	// ======================================================================
	// Interrupt status, cleared by reading it; only reported bits clear
	assign ist_set = {viol_set, flt_set[`FLT_DBL_BIT], flt_set[`FLT_SGL_BIT]};
	assign ist_clr = (rd_fin && hit_ist) ? prdata_q[2:0] : 3'h0;

	fault_flag_bank #(
		.N(3)
	) u_ist (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.set_i    (ist_set),
		.clr_i    (ist_clr),
		.flags_q  (ist_q)
	);

	// Level interrupt from unmasked status
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			irq_q <= 1'b0;
		else
			irq_q <= |(ist_q & imask_q);
	end
	assign irq = irq_q;

	// ======================================================================
	// Assertions
	a_dbl_set:
	assert property (@(posedge core_clk) disable iff (!rst_n)
		rd_done && rd_ecc_double |=> flt_q[`FLT_DBL_BIT])
	else $error("double flag not set after double fault");
	a_dbl_clear:
	assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_en && hit_flt && pwdata[1] && !flt_set[1] |=> !flt_q[1])
	else $error("double flag not cleared by writing one");
	a_sgl_set:
	assert property (@(posedge core_clk) disable iff (!rst_n)
		rd_done && !ign_q && rd_ecc_single && !rd_ecc_double |=> flt_q[0])
	else $error("single flag not set after corrected fault");
	a_sgl_keep:
	assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_en && hit_flt && !pwdata[0] && flt_q[0] |=> flt_q[0])
	else $error("single flag lost on a zero write");
	a_parity_excl:
	assert property (@(posedge core_clk) disable iff (!rst_n)
		rd_done && rd_ecc_double && !rd_busy_collide && !flt_q[0] |=> !flt_q[0])
	else $error("double fault also raised single flag");
	a_collide_both:
	assert property (@(posedge core_clk) disable iff (!rst_n)
		rd_done && rd_busy_collide && !ign_q |=> flt_q == 2'h3)
	else $error("collision did not raise both flags");
	a_flag_cause:
	assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(flt_q[1]) |-> $past(rd_done))
	else $error("double flag rose without a read one cycle before");
	a_no_shrink:
	assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_en && hit_prot && !cand_grows && !nv_load_valid |=> $stable(prot_q))
	else $error("protection shrank on a write");
	a_nv_load:
	assert property (@(posedge core_clk) disable iff (!rst_n)
		nv_load_valid |=> prot_q.open == $past(nv_prot_byte[7])
			&& prot_q.hsize == $past(nv_prot_byte[4:3]))
	else $error("protection not loaded from the nonvolatile byte");
	a_viol_set:
	assert property (@(posedge core_clk) disable iff (!rst_n)
		cmd_req && !viol_q && cmd_is_prot |=> viol_q && cmd_refuse && !cmd_start)
	else $error("protected request not refused");
	a_blk_erase:
	assert property (@(posedge core_clk) disable iff (!rst_n)
		cmd_req && cmd_kind == flash_guard_pkg::CMD_BLOCK_ERASE && any_protected
			|=> !cmd_start)
	else $error("block erase started over protected sector");
	a_launch_block:
	assert property (@(posedge core_clk) disable iff (!rst_n)
		cmd_req && viol_q |=> cmd_refuse && !cmd_start)
	else $error("command launched while violation flag set");
	a_rsvd_one:
	assert property (@(posedge core_clk) disable iff (!rst_n)
		setup_acc && !pwrite && hit_prot |=> prdata[6] && prdata[2:0] == 3'h0)
	else $error("protection reserved bits read wrong");

endmodule

`default_nettype wire

//--- rtl/flash_guard_consts.svh
// Register indices, field positions, reset values and sizes of the flash guard
`ifndef FLASH_GUARD_CONSTS_SVH
`define FLASH_GUARD_CONSTS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define FLT_IDX        16'h3027
`define PROT_IDX       16'h3028
`define CFG_IDX        16'h3030
`define CST_IDX        16'h3031
`define IST_IDX        16'h3032
`define IMSK_IDX       16'h3033
`define FLT_ADDR       (`FLT_IDX * 16'h0004)
`define PROT_ADDR      (`PROT_IDX * 16'h0004)
`define CFG_ADDR       (`CFG_IDX * 16'h0004)
`define CST_ADDR       (`CST_IDX * 16'h0004)
`define IST_ADDR       (`IST_IDX * 16'h0004)
`define IMSK_ADDR      (`IMSK_IDX * 16'h0004)

// ==========================================================================
// Field positions
`define FLT_SGL_BIT    0
`define FLT_DBL_BIT    1
`define PROT_OPEN_BIT  7
`define PROT_RSV_BIT   6
`define PROT_HDIS_BIT  5
`define PROT_HS_HI     4
`define PROT_HS_LO     3
`define CFG_IGN_BIT    0
`define CST_VIOL_BIT   4
`define IRQ_SGL_BIT    0
`define IRQ_DBL_BIT    1
`define IRQ_VIOL_BIT   2

// ==========================================================================
// Reset values and sizes
`define PROT_RST_OPEN  1'b1
`define PROT_RST_HDIS  1'b1
`define PROT_RST_HS    2'h0
`define HIGH_MIN_SIZE  17'h00800
`define FLASH_TOP_P1   17'h10000

`endif

//--- rtl/flash_guard_pkg.sv
// Types shared by the flash guard modules
package flash_guard_pkg;

	// Kind of a program or erase request from the command sequencer
	typedef enum logic [1:0] {
		CMD_PROGRAM,
		CMD_SECTOR_ERASE,
		CMD_BLOCK_ERASE,
		CMD_OTHER
	} cmd_kind_t;

	// Stored fields of the protection register
	typedef struct packed {
		logic       open;
		logic       hdis;
		logic [1:0] hsize;
	} prot_fields_t;

endpackage

//--- rtl/fault_flag_bank.sv
// Bank of sticky flags, each set by an event and cleared by a strobe
`timescale 1ns/1ps
`default_nettype none

module fault_flag_bank #(
	parameter int N = 2
) (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	// Set and clear strobes, one bit per flag
	input  wire logic [N-1:0] set_i,
	input  wire logic [N-1:0] clr_i,
	// Flag state
	output var  logic [N-1:0] flags_q
);

	// Refuse an empty bank
	if (N < 1)
	begin : g_bad
		$error("fault_flag_bank needs at least one flag");
	end

	// One flop per flag; an event in the clearing cycle wins
	for (genvar i = 0; i < N; i++)
	begin : g_flag
		always_ff @(posedge core_clk or negedge rst_n)
		begin
			if (!rst_n)
				flags_q[i] <= 1'b0;
			else if (set_i[i])
				flags_q[i] <= 1'b1;
			else if (clr_i[i])
				flags_q[i] <= 1'b0;
		end
	end

endmodule

`default_nettype wire

//--- rtl/prot_range_check.sv
// Decodes protection fields into address checks and growth checks
`timescale 1ns/1ps
`default_nettype none
`include "flash_guard_consts.svh"

module prot_range_check (
	// Current and candidate protection fields
	input  wire flash_guard_pkg::prot_fields_t cur,
	input  wire flash_guard_pkg::prot_fields_t cand,
	// Address of a program or erase request
	input  wire logic [15:0]                   addr,
	// Results
	output logic                               addr_protected,
	output logic                               any_protected,
	output logic                               cand_grows
);

	logic [16:0] high_base;
	logic        in_high;

	// High range ends at the top address and grows by powers of two
	assign high_base = `FLASH_TOP_P1 - (`HIGH_MIN_SIZE << cur.hsize);
	assign in_high   = !cur.hdis && ({1'b0, addr} >= high_base);

	// Open set: the range is protected; clear: the range is the only hole
	always_comb
	begin
		if (cur.open)
		begin
			addr_protected = in_high;
			any_protected  = !cur.hdis;
		end
		else
		begin
			addr_protected = !in_high;
			any_protected  = 1'b1;
		end
	end

	// Candidate protected set must contain the current protected set
	always_comb
	begin
		if (cur.open && cand.open)
			cand_grows = cur.hdis || (!cand.hdis && (cand.hsize >= cur.hsize));
		else if (!cur.open && !cand.open)
			cand_grows = cand.hdis || (!cur.hdis && (cand.hsize <= cur.hsize));
		else if (cur.open)
			cand_grows = cur.hdis || cand.hdis;
		else
			cand_grows = 1'b0;
	end

endmodule

`default_nettype wire

//--- sim/flash_guard_tb.sv
// Self-checking testbench for the flash guard block
`timescale 1ns/1ps
`default_nettype none
`include "flash_guard_consts.svh"

module flash_guard_tb;

	// ==========================================================================
	// Signals
	logic                       core_clk;
	logic                       rst_n;
	logic [15:0]                paddr;
	logic                       psel;
	logic                       penable;
	logic                       pwrite;
	logic [31:0]                pwdata;
	logic [3:0]                 pstrb;
	logic [31:0]                prdata;
	logic                       pready;
	logic                       pslverr;
	logic                       nv_load_valid;
	logic [7:0]                 nv_prot_byte;
	logic                       rd_done;
	logic                       rd_ecc_single;
	logic                       rd_ecc_double;
	logic                       rd_busy_collide;
	logic                       cmd_req;
	flash_guard_pkg::cmd_kind_t cmd_kind;
	logic [15:0]                cmd_addr;
	logic                       cmd_start;
	logic                       cmd_refuse;
	logic                       launch_blocked;
	logic                       irq;
	logic                       err_seen;
	int                         miscompares;
	int                         checks_done;

	// ==========================================================================
	// Design under test
	flash_guard uut (
		.core_clk        (core_clk),
		.rst_n           (rst_n),
		.paddr           (paddr),
		.psel            (psel),
		.penable         (penable),
		.pwrite          (pwrite),
		.pwdata          (pwdata),
		.pstrb           (pstrb),
		.prdata          (prdata),
		.pready          (pready),
		.pslverr         (pslverr),
		.nv_load_valid   (nv_load_valid),
		.nv_prot_byte    (nv_prot_byte),
		.rd_done         (rd_done),
		.rd_ecc_single   (rd_ecc_single),
		.rd_ecc_double   (rd_ecc_double),
		.rd_busy_collide (rd_busy_collide),
		.cmd_req         (cmd_req),
		.cmd_kind        (cmd_kind),
		.cmd_addr        (cmd_addr),
		.cmd_start       (cmd_start),
		.cmd_refuse      (cmd_refuse),
		.launch_blocked  (launch_blocked),
		.irq             (irq)
	);

	// Free-running 100 MHz clock
	always #5 core_clk = ~core_clk;

	// ==========================================================================
	// Helper tasks
	task automatic test_done;
		$display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Compare one value, report a mismatch at once
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One APB transfer, held until pready is sampled high; only the watchdog ends a wait
	task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1);
		chk("apb access cycles", 32'h2, n);
		r = prdata;
		err_seen = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(a, 1'b1, d, r);
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] e, input string nm);
		logic [31:0] r;
		apb(a, 1'b0, 32'h0, r);
		chk(nm, e, r);
	endtask

	// Flash array read report pulse with its qualifiers
	task automatic ev(input logic s, input logic d, input logic c);
		@(posedge core_clk);
		rd_done         <= 1'b1;
		rd_ecc_single   <= s;
		rd_ecc_double   <= d;
		rd_busy_collide <= c;
		@(posedge core_clk);
		rd_done         <= 1'b0;
		rd_ecc_single   <= 1'b0;
		rd_ecc_double   <= 1'b0;
		rd_busy_collide <= 1'b0;
	endtask

	// Request pulse; answer {launch_blocked, refuse, start} one cycle later
	task automatic cmd(input flash_guard_pkg::cmd_kind_t k, input logic [15:0] a,
		input logic [2:0] e, input string nm);
		logic [2:0] r;
		@(posedge core_clk);
		cmd_req  <= 1'b1;
		cmd_kind <= k;
		cmd_addr <= a;
		@(posedge core_clk);
		cmd_req  <= 1'b0;
		@(posedge core_clk);
		r = {launch_blocked, cmd_refuse, cmd_start};
		chk(nm, {29'h0, e}, {29'h0, r});
	endtask

	// ==========================================================================
	// Scenarios
	task automatic t_reset;
		rd(`FLT_ADDR, 32'h00, "fault reset");
		rd(`PROT_ADDR, 32'hE0, "prot reset");
		chk("irq reset", 32'h0, {31'h0, irq});
		rd(16'hC0D0, 32'h00, "unmapped data");
		chk("unmapped err", 32'h1, {31'h0, err_seen});
	endtask

	task automatic t_faults;
		ev(1'b0, 1'b1, 1'b0);
		rd(`FLT_ADDR, 32'h02, "double only");
		wr(`FLT_ADDR, 32'h00);
		rd(`FLT_ADDR, 32'h02, "double zero write");
		pstrb <= 4'h0;
		wr(`FLT_ADDR, 32'h02);
		pstrb <= 4'hF;
		rd(`FLT_ADDR, 32'h02, "strobe off write");
		wr(`FLT_ADDR, 32'hFE);
		rd(`FLT_ADDR, 32'h00, "double cleared");
		ev(1'b1, 1'b0, 1'b0);
		rd(`FLT_ADDR, 32'h01, "single only");
		wr(`FLT_ADDR, 32'h02);
		rd(`FLT_ADDR, 32'h01, "single zero write");
		wr(`FLT_ADDR, 32'h01);
		rd(`FLT_ADDR, 32'h00, "single cleared");
		ev(1'b0, 1'b0, 1'b1);
		rd(`FLT_ADDR, 32'h03, "collision both");
		wr(`FLT_ADDR, 32'h03);
		wr(`CFG_ADDR, 32'h01);
		ev(1'b1, 1'b0, 1'b0);
		rd(`FLT_ADDR, 32'h00, "single ignored");
		ev(1'b0, 1'b0, 1'b1);
		rd(`FLT_ADDR, 32'h02, "collision ignored");
		wr(`FLT_ADDR, 32'h03);
		wr(`CFG_ADDR, 32'h00);
	endtask

	task automatic t_irq;
		logic [31:0] r;
		apb(`IST_ADDR, 1'b0, 32'h0, r);
		wr(`IMSK_ADDR, 32'h00);
		ev(1'b0, 1'b1, 1'b0);
		repeat (3) @(posedge core_clk);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(`IMSK_ADDR, 32'h02);
		repeat (2) @(posedge core_clk);
		chk("irq raised", 32'h1, {31'h0, irq});
		rd(`IST_ADDR, 32'h02, "irq status");
		repeat (2) @(posedge core_clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		wr(`FLT_ADDR, 32'h03);
	endtask

	task automatic t_prot;
		wr(`PROT_ADDR, 32'h88);
		rd(`PROT_ADDR, 32'hC8, "prot grow");
		wr(`PROT_ADDR, 32'hE0);
		rd(`PROT_ADDR, 32'hC8, "prot shrink");
		wr(`PROT_ADDR, 32'hD0);
		rd(`PROT_ADDR, 32'hC8, "size locked");
		cmd(flash_guard_pkg::CMD_PROGRAM, 16'hF000, 3'b110, "prog top");
		cmd(flash_guard_pkg::CMD_OTHER, 16'h0000, 3'b110, "blocked");
		rd(`CST_ADDR, 32'h10, "violation set");
		wr(`CST_ADDR, 32'h00);
		wr(`CST_ADDR, 32'h10);
		rd(`CST_ADDR, 32'h00, "violation clear");
		cmd(flash_guard_pkg::CMD_PROGRAM, 16'hEFFF, 3'b001, "prog below");
		cmd(flash_guard_pkg::CMD_BLOCK_ERASE, 16'h0000, 3'b110, "block erase");
		wr(`CST_ADDR, 32'h10);
		cmd(flash_guard_pkg::CMD_SECTOR_ERASE, 16'hFFFF, 3'b110, "sector top");
		wr(`CST_ADDR, 32'h10);
	endtask

	task automatic t_nvload;
		@(posedge core_clk);
		nv_prot_byte  <= 8'h4F;
		nv_load_valid <= 1'b1;
		@(posedge core_clk);
		nv_load_valid <= 1'b0;
		rd(`PROT_ADDR, 32'h48, "prot loaded");
		cmd(flash_guard_pkg::CMD_PROGRAM, 16'hF000, 3'b001, "hole open");
		// Top sector left open, so the stored protection byte may be reprogrammed
		cmd(flash_guard_pkg::CMD_PROGRAM, 16'hFF7C, 3'b001, "prot byte prog");
		cmd(flash_guard_pkg::CMD_PROGRAM, 16'hEFFF, 3'b110, "outside hole");
		wr(`CST_ADDR, 32'h10);
		wr(`PROT_ADDR, 32'hC8);
		rd(`PROT_ADDR, 32'h48, "open locked");
	endtask

	// ==========================================================================
	// Main sequence: reset, then every scenario
	initial
	begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		{psel, penable, pwrite, nv_load_valid, cmd_req} = 5'h00;
		{rd_done, rd_ecc_single, rd_ecc_double, rd_busy_collide} = 4'h0;
		paddr = 16'h0000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		nv_prot_byte = 8'hFF;
		cmd_kind = flash_guard_pkg::CMD_OTHER;
		cmd_addr = 16'h0000;
		err_seen = 1'b0;
		miscompares = 0;
		checks_done = 0;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset;
		t_faults;
		t_irq;
		t_prot;
		t_nvload;
		test_done;
	end

	// Watchdog against a hang
	initial
	begin
		#100000;
		miscompares++;
		test_done;
	end

endmodule

`default_nettype wire
